// ---- hpoc_host.sv ----
`timescale 1ns/100ps
`default_nettype none

module hpoc_host (
  input  wire logic       sys_clk,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [6:0] host_addr,
  output logic      [7:0] host_wdata
);
  // ----------------------------------------------------------
  // host side of the register port
  // ----------------------------------------------------------
  initial begin
    {host_wr, host_rd, host_addr, host_wdata} = '0;
  end

  // one byte access, held across the taking edge
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d);
    if (wr && a == 7'h7f && d > 8'h0f) d = 8'h0f;
    @(posedge sys_clk);
    #1;
    {host_wr, host_rd, host_addr, host_wdata} = {wr, !wr, a, d};
    @(posedge sys_clk);
    #1;
    // idle lines show inverted values so stale data never looks live
    {host_wr, host_rd, host_addr, host_wdata} = {2'b00, ~a, ~d};
  endtask : access
endmodule : hpoc_host

`default_nettype wire

// ---- hpoc_pkg.sv ----
package hpoc_pkg;

  // ---------------------------------------------------------------
  // register map (full 15-bit address = page * 128 + offset)
  // ---------------------------------------------------------------
  localparam logic [14:0] OUT7_CTRL_ADDR    = 15'h04af;
  localparam logic [14:0] OUT8_CTRL_ADDR    = 15'h04b0;
  localparam logic [14:0] OUT9_CTRL_ADDR    = 15'h04b1;
  localparam logic [14:0] HOST_CTL_ADDR     = 15'h04fe;
  localparam logic [14:0] PAGE_SEL_ADDR     = 15'h04ff;
  localparam int          OUT_COUNT         = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  OUT_CTRL_RST      = 8'h01;
  localparam logic [7:0]  HOST_CTL_RST      = 8'h00;
  localparam logic [7:0]  PAGE_SEL_RST      = 8'h00;

  // ---------------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------------
  localparam int          OUT_EN_BIT        = 0;
  localparam int          OUT_STOP_BIT      = 1;
  localparam int          OUT_STOP_HIGH_BIT = 2;
  localparam int          OUT_HALT_TRI_BIT  = 3;
  localparam int          OUT_SYNTH_LSB     = 4;
  localparam int          OUT_SYNTH_MSB     = 6;
  localparam logic [7:0]  OUT_CTRL_WMASK    = 8'h7f;
  localparam int          LOCKOUT_BIT       = 7;
  localparam int          STATUS_BIT        = 0;
  localparam logic [7:0]  PAGE_LAST         = 8'h0f;

endpackage : hpoc_pkg

// ---- hpoc_regs.sv ----
// Operation
// [RULE_01] Output 7, 8 and 9 control registers hold synth select 6:4, tristate halt, stop-high, stop, enable, bit 7 reserved, reset 0x01.
// [RULE_02] The three output control registers behave field for field like the output-0 control register.
// [RULE_03] While lockout is set, writes to every register other than the host-port control register are ignored.
// [RULE_04] While lockout is clear, writes to all writable registers are taken normally.
// [RULE_05] Bit 0 of the host-port control register reports whether the last host access succeeded.
// [RULE_06] The page-select value is an unsigned page number choosing the 128-byte block that host accesses reach.
// [RULE_07] Page values 0x00 to 0x0f map to pages 0 to 15 and higher values are reserved and not to be written.
// [RULE_08] The internal address is the page-select value above the low seven bits of the host address.
`timescale 1ns/100ps
`default_nettype none

module hpoc_regs
  import hpoc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [6:0] host_addr,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata,
  output logic            host_rvalid,
  output logic      [7:0] page_select,
  output logic            lockout,
  output logic            access_failed,
  output logic      [2:0] out_enable,
  output logic      [2:0] out_stop,
  output logic      [2:0] out_stop_high,
  output logic      [2:0] out_halt_tristate,
  output logic      [8:0] out_synth_sel
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  out_ctrl_q [OUT_COUNT];
  logic [7:0]  page_q;
  logic        lock_q;
  logic        fail_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [14:0] full_addr;
  logic        page_ok;
  logic        hit_ctl;
  logic        hit_page;
  logic [2:0]  hit_out;
  logic        any_out;
  logic        wr_go;
  logic        access;
  logic        acc_ok;
  logic [7:0]  rd_mux;

  // page above offset gives the internal address
  assign full_addr = {page_q, host_addr};                     // see [RULE_08]
  // only pages 0..15 exist; reserved pages reach no output control register
  assign page_ok   = (page_q <= PAGE_LAST);                   // see [RULE_07]
  // host-port and page registers answer in every page so a bad page can be undone
  assign hit_ctl   = (host_addr == HOST_CTL_ADDR[6:0]);
  assign hit_page  = (host_addr == PAGE_SEL_ADDR[6:0]);
  assign hit_out[0] = page_ok && (full_addr == OUT7_CTRL_ADDR); // see [RULE_06]
  assign hit_out[1] = page_ok && (full_addr == OUT8_CTRL_ADDR);
  assign hit_out[2] = page_ok && (full_addr == OUT9_CTRL_ADDR);
  assign any_out   = |hit_out;
  assign access    = host_wr || host_rd;
  // lockout leaves only the host-port control register writable
  assign wr_go     = host_wr && !lock_q;                      // see [RULE_03]
  // an access succeeds when it reaches a register that takes it
  always_comb begin
    if (host_wr) begin
      acc_ok = hit_ctl || ((hit_page || any_out) && !lock_q); // see [RULE_04]
    end else begin
      acc_ok = hit_ctl || hit_page || any_out;
    end
  end

  // read mux; unmapped and refused reads give zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit_ctl) begin
      rd_mux[LOCKOUT_BIT] = lock_q;
      rd_mux[STATUS_BIT]  = fail_q;
    end else if (hit_page) begin
      rd_mux = page_q;
    end else begin
      for (int i = 0; i < OUT_COUNT; i++) begin
        if (hit_out[i]) begin
          rd_mux = out_ctrl_q[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output control registers
  // ---------------------------------------------------------------
  // same field layout for all three; reserved bit 7 is never stored
  // one process for the whole array so each word has a single driver
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < OUT_COUNT; i++) begin
        out_ctrl_q[i] <= OUT_CTRL_RST;                        // see [RULE_01]
      end
    end else if (clk_en && wr_go) begin
      for (int i = 0; i < OUT_COUNT; i++) begin
        if (hit_out[i]) begin
          out_ctrl_q[i] <= host_wdata & OUT_CTRL_WMASK;       // see [RULE_02]
        end
      end
    end
  end

  // field fan-out, one slice per output
  for (genvar g = 0; g < OUT_COUNT; g++) begin : g_out
    assign out_enable[g]        = out_ctrl_q[g][OUT_EN_BIT];
    assign out_stop[g]          = out_ctrl_q[g][OUT_STOP_BIT];
    assign out_stop_high[g]     = out_ctrl_q[g][OUT_STOP_HIGH_BIT];
    assign out_halt_tristate[g] = out_ctrl_q[g][OUT_HALT_TRI_BIT];
    assign out_synth_sel[3*g +: 3] = out_ctrl_q[g][OUT_SYNTH_MSB:OUT_SYNTH_LSB];
  end

  // ---------------------------------------------------------------
  // page select
  // ---------------------------------------------------------------
  // reserved values are stored as written; they only make accesses fail
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_q <= PAGE_SEL_RST;
    end else if (clk_en && wr_go && hit_page) begin
      page_q <= host_wdata;                                   // see [RULE_06]
    end
  end

  // ---------------------------------------------------------------
  // host-port control: lockout and access status
  // ---------------------------------------------------------------
  // lockout itself stays writable, otherwise it could never be released
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_q <= HOST_CTL_RST[LOCKOUT_BIT];
    end else if (clk_en && host_wr && hit_ctl) begin
      lock_q <= host_wdata[LOCKOUT_BIT];                      // see [RULE_03]
    end
  end

  // status follows every access; zero means the last one succeeded
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fail_q <= HOST_CTL_RST[STATUS_BIT];
    end else if (clk_en && access) begin
      fail_q <= !acc_ok;                                      // see [RULE_05]
    end
  end

  // ---------------------------------------------------------------
  // read return
  // ---------------------------------------------------------------
  // a write in the same cycle takes priority and the read is dropped
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= host_rd && !host_wr;
      if (host_rd && !host_wr) begin
        rdata_q <= rd_mux;                                    // see [RULE_08]
      end
    end
  end

  assign host_rdata    = rdata_q;
  assign host_rvalid   = rvalid_q;
  assign page_select   = page_q;
  assign lockout       = lock_q;
  assign access_failed = fail_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  for (genvar a = 0; a < OUT_COUNT; a++) begin : g_ast
    AST_OUT_RSVD_ZERO: assert property (out_ctrl_q[a][7] == 1'b0) // see [RULE_01]
      else $error("reserved output control bit set");
    AST_OUT_WRITE: assert property ( // see [RULE_02]
      clk_en && host_wr && !lock_q && hit_out[a]
      |=> out_ctrl_q[a] == ($past(host_wdata) & OUT_CTRL_WMASK))
      else $error("output control write not stored");
  end

  AST_LOCK_HOLDS: assert property ( // see [RULE_03]
    clk_en && host_wr && lock_q && !hit_ctl
    |=> $stable(page_q) && $stable(out_enable) && $stable(out_synth_sel) && fail_q)
    else $error("write taken under lockout");

  AST_UNLOCK_PAGE: assert property ( // see [RULE_04]
    clk_en && host_wr && !lock_q && hit_page |=> page_q == $past(host_wdata) && !fail_q)
    else $error("page write refused while unlocked");

  AST_STATUS_OK: assert property ( // see [RULE_05]
    clk_en && access && hit_ctl |=> !fail_q)
    else $error("status not cleared by good access");

  AST_PAGE_READ: assert property ( // see [RULE_06]
    clk_en && host_rd && !host_wr && page_q == OUT8_CTRL_ADDR[14:7]
    && host_addr == OUT8_CTRL_ADDR[6:0]
    |=> host_rvalid && host_rdata == out_ctrl_q[1])
    else $error("paged read returned wrong register");

  AST_RSVD_PAGE: assert property ( // see [RULE_07]
    clk_en && access && page_q > PAGE_LAST && !hit_ctl && !hit_page |=> fail_q)
    else $error("access on reserved page not flagged");

  AST_RVALID: assert property ( // see [RULE_08]
    clk_en && host_rd && !host_wr |=> host_rvalid)
    else $error("read answer missing");

  AST_RVALID_DROP: assert property ( // see [RULE_08]
    clk_en && !(host_rd && !host_wr) |=> !host_rvalid)
    else $error("read answer without a read");

  AST_FREEZE: assert property (!clk_en |=> $stable(page_q) && $stable(lock_q) && $stable(fail_q))
    else $error("state moved with clock enable low");

  COV_LOCKED_WRITE: cover property (clk_en && host_wr && lock_q && hit_page);
  COV_OUT_WRITE:    cover property (clk_en && wr_go && any_out);
  COV_BAD_PAGE:     cover property (clk_en && access && !page_ok && !hit_ctl && !hit_page);
  COV_UNLOCK:       cover property (lock_q ##1 !lock_q);

endmodule : hpoc_regs

`default_nettype wire

// ---- hpoc_regs_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module hpoc_regs_bench;
  import hpoc_pkg::*;
  logic       sys_clk, sys_rst, clk_en, host_wr, host_rd, host_rvalid, lockout;
  logic       access_failed;
  logic [6:0] host_addr;
  logic [7:0] host_wdata, host_rdata, page_select, d;
  logic [7:0] v [3];
  logic [2:0] out_enable, out_stop, out_stop_high, out_halt_tristate;
  logic [8:0] out_synth_sel;
  logic [31:0] rng_q;
  logic [7:0] exp_q [$];
  logic       en_seen;
  int         err_count, n_compared;

  hpoc_host host (.sys_clk(sys_clk), .host_wr(host_wr), .host_rd(host_rd),
                  .host_addr(host_addr), .host_wdata(host_wdata));
  hpoc_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .page_select(page_select),
    .lockout(lockout), .access_failed(access_failed), .out_enable(out_enable),
    .out_stop(out_stop), .out_stop_high(out_stop_high),
    .out_halt_tristate(out_halt_tristate), .out_synth_sel(out_synth_sel));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  always #20 sys_clk = ~sys_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs

  task automatic rd(input logic [6:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    host.access(1'b0, a, 8'h00);
  endtask : rd

  // read answers are matched against the oldest note, mid-cycle
  // enable seen at the last rising edge; a held answer is not a new one
  always @(posedge sys_clk) begin
    en_seen <= clk_en;
  end

  always @(negedge sys_clk) begin
    if (host_rvalid === 1'b1 && en_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        check({7'h00, host_rvalid}, 8'h00);
      end else begin
        check(host_rdata, exp_q.pop_front());
      end
    end
  end

  // watchdog, far beyond the roughly 80 cycles the run needs
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {sys_clk, sys_rst, clk_en, rng_q, err_count, n_compared} = {3'b011, 32'd55343, 64'd0};
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    check(8'(out_enable), 8'h07);
    check({7'h00, access_failed}, 8'h00);
    host.access(1'b1, 7'h7f, 8'h09);
    check(page_select, 8'h09);
    rd(7'h7f, 8'h09);
    for (int i = 0; i < 3; i++) rd(7'(7'h2f + i), OUT_CTRL_RST);
    $display("reset values done");
    for (int i = 0; i < 3; i++) begin
      rng_q = xs(rng_q);
      d = rng_q[7:0] | 8'h80;
      v[i] = d & OUT_CTRL_WMASK;
      host.access(1'b1, 7'(7'h2f + i), d);
      check({1'b0, out_synth_sel[3*i+:3], out_halt_tristate[i], out_stop_high[i], out_stop[i],
             out_enable[i]}, {1'b0, d[6:0]});
      rd(7'(7'h2f + i), v[i]);
    end
    $display("field writes done");
    host.access(1'b1, 7'h7e, 8'h80);
    check({7'h00, lockout}, 8'h01);
    rd(7'h7e, 8'h80);
    host.access(1'b1, 7'h2f, ~v[0]);
    check({7'h00, access_failed}, 8'h01);
    rd(7'h7e, 8'h81);
    host.access(1'b1, 7'h7f, 8'h08);
    check(page_select, 8'h09);
    rd(7'h2f, v[0]);
    host.access(1'b1, 7'h7e, 8'h00);
    check({7'h00, lockout}, 8'h00);
    host.access(1'b1, 7'h2f, 8'h35);
    check({7'h00, access_failed}, 8'h00);
    rd(7'h2f, 8'h35);
    $display("lockout done");
    rd(7'h00, 8'h00);
    check({7'h00, access_failed}, 8'h01);
    host.access(1'b1, 7'h7f, 8'h08);
    rd(7'h2f, 8'h00);
    host.access(1'b1, 7'h7f, 8'h09);
    rd(7'h30, v[1]);
    $display("paging done");
    // a held read answer must not count as a second one
    clk_en = 1'b0;
    host.access(1'b1, 7'h31, ~v[2]);
    check({7'h00, out_enable[2]}, {7'h00, v[2][0]});
    clk_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    check(8'(exp_q.size()), 8'h00);
    $display("clock enable done");
    // second reset in mid-run brings every register back
    #1 sys_rst = 1'b1;
    @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    check(page_select, PAGE_SEL_RST);
    check(8'(out_enable), 8'h07);
    host.access(1'b1, 7'h7f, 8'h09);
    for (int i = 0; i < 3; i++) rd(7'(7'h2f + i), OUT_CTRL_RST);
    repeat (2) @(posedge sys_clk);
    check(8'(exp_q.size()), 8'h00);
    $display("second reset done");
    wrap_up();
  end
endmodule : hpoc_regs_bench

`default_nettype wire
